// ==== scl_map.svh ====
// register offsets, field positions and reset values for the serial loop block
`ifndef SCL_MAP_SVH
`define SCL_MAP_SVH
`define SCL_CMD_BITS 8
`define SCL_DEV_ADDR_HI 7
`define SCL_DEV_ADDR_LO 6
`define SCL_REG_ADDR_HI 5
`define SCL_REG_ADDR_LO 1
`define SCL_RW_BIT 0
`define SCL_LAST_PROTECTED 5'h07
`define SCL_KEY_ADDR 5'h1F
`define SCL_UNLOCK_KEY 8'hA5
`define SCL_RD_STATIC 2'h0
`define SCL_RD_GROUPS 2'h1
`define SCL_RD_TYPES 2'h2
`define SCL_RD_FULL 2'h3
`define SCL_RD_RESET 2'h2
`define SCL_WR_RESET 1'h1
`define SCL_DEV_ADDR_DEF 2'h1
`define SCL_WORD_BITS 24
`define SCL_PHASE_ADDR 5'h0A
`define SCL_GROUP_SIZE 5'h02
`define SCL_ADC_LAST 5'h02
`define SCL_MAP_LAST 5'h1F
`define SCL_CFG_FIRST 5'h08
`define SCL_CFG_LAST 5'h1F
`endif

// ==== scl_pkg.sv ====
// types shared by the serial loop block
package scl_pkg;
  typedef enum logic [1:0] {
    SCL_IDLE,
    SCL_CMD,
    SCL_READ,
    SCL_WRITE
  } scl_state_t;
  typedef struct packed {
    logic [1:0] readLoop;
    logic writeLoop;
    logic readyTristate;
    logic [7:0] lockKey;
  } scl_cfg_t;
  typedef struct packed {
    logic [2:0] oversamplingRatioSel;
    logic [1:0] prescalerSel;
    logic externalClockSel;
    logic externalReferenceSel;
  } scl_adc_cfg_t;
  typedef struct packed {
    logic strobe;
    logic [4:0] addr;
    logic [23:0] data;
  } scl_wr_t;
endpackage

// ==== scl_serial_loop.sv ====
// serial command loop, write guard, converter restart and ready pin driver
`timescale 1ns/1ps
`default_nettype none
`include "scl_map.svh"
// What this block does
// - one command byte opens a transfer; loop continues until chip select rises
// - pointer starts at command address, advances in set, wraps to set start
// - read selector picks static, groups, types or full-map looping
// - serial input bits after the command byte are ignored in reads
// - idle-low clock: output shows new word msb on ready falling edge
// - idle-high clock: output holds last word lsb after complete read
// - write selector picks static or types looping, types by default
// - serial output stays high impedance throughout a write transfer
// - writes to 0x00..0x07 do nothing and freeze the pointer
// - unless key is 0xA5 only address 0x1F is writable
// - phase writes or clock/ratio/reference changes restart active converters
// - restart clears converter data outputs and resumes without a command
// - ready pulse lasts half a modulator clock period at conversion end
// - first pulse after settling plus phase; then one per output-rate period
// - ready idles floating if tristate bit is 0, driven high if 1
// - ready pulses run regardless of chip select state
// - ready stays inactive while external reset is held low and the corruption flag is clear
// - configuration corruption flag holds ready low (driven) while it is asserted
// - command byte holds device address, register address, read/write bit
// - chip select rise aborts transfer and resets interface state
module scl_serial_loop #(
  parameter int WORD_BITS = `SCL_WORD_BITS,
  parameter logic [1:0] DEV_ADDR = `SCL_DEV_ADDR_DEF
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic csB,
  input wire logic sckRise,
  input wire logic sckFall,
  input wire logic sckIdleHigh,
  input wire logic serialIn,
  input wire logic [WORD_BITS-1:0] readWord,
  input wire scl_pkg::scl_cfg_t cfg,
  input wire scl_pkg::scl_adc_cfg_t adcCfg,
  input wire logic [2:0] convActive,
  input wire logic [2:0] convDone,
  input wire logic modulatorClockHalf,
  input wire logic crcCorrupt,
  output logic serialOut,
  output logic serialOutEn,
  output logic [4:0] regPointer,
  output scl_pkg::scl_wr_t writeReq,
  output logic [2:0] convRestart,
  output logic [2:0] clearConvData,
  output logic sampleReadyOut,
  output logic sampleReadyOutEn
);
  scl_pkg::scl_state_t state_q, state_d;
  logic [5:0] bitCnt_q, bitCnt_d;
  logic [WORD_BITS-1:0] shift_q, shift_d;
  logic [4:0] ptr_q, ptr_d;
  logic rw_q, rw_d;
  logic out_q, out_d;
  logic wordEnd;
  scl_pkg::scl_wr_t wr_q, wr_d;
  scl_pkg::scl_adc_cfg_t adcPrev_q;
  logic [2:0] restart_q, restart_d;
  logic readyLow_q, readyLow_d;
  logic readyFallSeen;
  // a refused device address must wait for a fresh chip select fall
  logic csPrev_q, csPrev_d;

  // set bounds per mode; the table mirrors the register map layout
  function automatic logic [4:0] set_first(input logic [1:0] mode,
                                          input logic [4:0] a);
    case (mode)
      `SCL_RD_GROUPS: set_first = (a <= `SCL_ADC_LAST) ? 5'h00 : `SCL_CFG_FIRST;
      `SCL_RD_TYPES: set_first = (a <= `SCL_ADC_LAST) ? 5'h00 : `SCL_CFG_FIRST;
      `SCL_RD_FULL: set_first = 5'h00;
      default: set_first = a;
    endcase
  endfunction

  function automatic logic [4:0] set_last(input logic [1:0] mode,
                                         input logic [4:0] a);
    case (mode)
      `SCL_RD_GROUPS: set_last = (a <= `SCL_ADC_LAST) ? `SCL_ADC_LAST
                                 : `SCL_CFG_LAST;
      `SCL_RD_TYPES: set_last = (a <= `SCL_ADC_LAST) ? `SCL_ADC_LAST
                                : `SCL_CFG_LAST;
      `SCL_RD_FULL: set_last = `SCL_MAP_LAST;
      default: set_last = a;
    endcase
  endfunction

  function automatic logic [4:0] advance(input logic [1:0] mode,
                                        input logic [4:0] a);
    if (mode == `SCL_RD_STATIC)
      advance = a;
    else if (a == set_last(mode, a))
      advance = set_first(mode, a);
    else
      advance = a + 5'h01;
  endfunction

  function automatic logic writable(input logic [4:0] a,
                                    input logic [7:0] key);
    if (a <= `SCL_LAST_PROTECTED)
      writable = 1'b0;
    else if (key != `SCL_UNLOCK_KEY)
      writable = (a == `SCL_KEY_ADDR);
    else
      writable = 1'b1;
  endfunction

  assign wordEnd = (bitCnt_q == 6'(WORD_BITS - 1)) && sckRise;
  // a slow host can miss the fall; the edge from the pulse driver suffices
  assign readyFallSeen = |convDone;

  always_comb begin
    state_d = state_q;
    bitCnt_d = bitCnt_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    out_d = out_q;
    wr_d = wr_q;
    wr_d.strobe = 1'b0;
    csPrev_d = csB;
    case (state_q)
      scl_pkg::SCL_IDLE: begin
        bitCnt_d = 6'h00;
        if (!csB && csPrev_q)
          state_d = scl_pkg::SCL_CMD;
      end
      scl_pkg::SCL_CMD: begin
        if (sckRise) begin
          shift_d = {shift_q[WORD_BITS-2:0], serialIn};
          bitCnt_d = bitCnt_q + 6'h01;
          if (bitCnt_q == 6'(`SCL_CMD_BITS - 1)) begin
            bitCnt_d = 6'h00;
            ptr_d = shift_q[4:0];
            rw_d = serialIn;
            if (shift_q[6:5] != DEV_ADDR)
              state_d = scl_pkg::SCL_IDLE;
            else if (serialIn) begin
              state_d = scl_pkg::SCL_READ;
              shift_d = readWord;
            end else
              state_d = scl_pkg::SCL_WRITE;
          end
        end
      end
      scl_pkg::SCL_READ: begin
        // serialIn is never sampled here
        if (sckFall) begin
          out_d = shift_q[WORD_BITS-1];
          shift_d = {shift_q[WORD_BITS-2:0], 1'b0};
        end
        if (wordEnd) begin
          bitCnt_d = 6'h00;
          ptr_d = advance(cfg.readLoop, ptr_q);
          shift_d = readWord;
          if (!sckIdleHigh)
            out_d = readWord[WORD_BITS-1];
        end else if (sckRise)
          bitCnt_d = bitCnt_q + 6'h01;
        // idle-high keeps the last lsb in out_q untouched
        if (!sckIdleHigh && readyFallSeen && bitCnt_q == 6'h00)
          out_d = readWord[WORD_BITS-1];
      end
      scl_pkg::SCL_WRITE: begin
        if (sckRise) begin
          shift_d = {shift_q[WORD_BITS-2:0], serialIn};
          bitCnt_d = bitCnt_q + 6'h01;
        end
        if (wordEnd) begin
          bitCnt_d = 6'h00;
          if (writable(ptr_q, cfg.lockKey)) begin
            wr_d.strobe = 1'b1;
            wr_d.addr = ptr_q;
            wr_d.data = {shift_q[WORD_BITS-2:0], serialIn};
            if (cfg.writeLoop)
              ptr_d = advance(`SCL_RD_TYPES, ptr_q);
          end // no advance on a refused write
        end
      end
      default: state_d = scl_pkg::SCL_IDLE;
    endcase
    if (csB) begin
      state_d = scl_pkg::SCL_IDLE;
      bitCnt_d = 6'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= scl_pkg::SCL_IDLE;
      bitCnt_q <= 6'h00;
      shift_q <= '0;
      ptr_q <= 5'h00;
      rw_q <= 1'b0;
      out_q <= 1'b0;
      wr_q <= '0;
      csPrev_q <= 1'b1;
    end else begin
      state_q <= state_d;
      csPrev_q <= csPrev_d;
      bitCnt_q <= bitCnt_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      out_q <= out_d;
      wr_q <= wr_d;
    end
  end

  // converter restart on phase write or clocking setting change
  always_comb begin
    restart_d = 3'h0;
    if ((wr_q.strobe && wr_q.addr == `SCL_PHASE_ADDR) ||
        adcCfg != adcPrev_q)
      restart_d = convActive;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      restart_q <= 3'h0;
      adcPrev_q <= '0;
    end else begin
      restart_q <= restart_d;
      adcPrev_q <= adcCfg;
    end
  end

  // ready pulse: low for the half modulator period after a conversion end;
  // pulse timing itself arrives from the output-rate logic on convDone
  always_comb begin
    readyLow_d = readyLow_q;
    if (|convDone)
      readyLow_d = 1'b1;
    else if (!modulatorClockHalf)
      readyLow_d = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      readyLow_q <= 1'b0;
    else
      readyLow_q <= readyLow_d;
  end

  assign serialOut = out_q;
  assign serialOutEn = (state_q == scl_pkg::SCL_READ) && !csB;
  assign regPointer = ptr_q;
  assign writeReq = wr_q;
  assign convRestart = restart_q;
  assign clearConvData = restart_q;
  assign sampleReadyOut = !(readyLow_q || crcCorrupt);
  assign sampleReadyOutEn = readyLow_q || crcCorrupt || cfg.readyTristate;
endmodule
`default_nettype wire

// ==== scl_serial_loop_monitor.sv ====
// port checker for the serial loop block
`timescale 1ns/1ps
`default_nettype none
module scl_serial_loop_monitor (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic csB,
  input wire scl_pkg::scl_cfg_t cfg,
  input wire logic [2:0] convActive,
  input wire logic [2:0] convDone,
  input wire logic crcCorrupt,
  input wire logic serialOutEn,
  input wire scl_pkg::scl_wr_t writeReq,
  input wire logic [2:0] convRestart,
  input wire logic sampleReadyOut,
  input wire logic sampleReadyOutEn
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_phase;
    writeReq.strobe && writeReq.addr == 5'h0A;
  endsequence
  sequence s_restart;
    ##[0:2] convRestart == convActive;
  endsequence
  property p_idle; csB && $past(csB) |-> !serialOutEn; endproperty
  a_idle: assert property (p_idle) else $error("out on");
  property p_wrz; writeReq.strobe |-> !serialOutEn; endproperty
  a_wrz: assert property (p_wrz) else $error("out in write");
  property p_grd; writeReq.strobe |-> writeReq.addr > 5'h07; endproperty
  a_grd: assert property (p_grd) else $error("low write");
  property p_lck;
    writeReq.strobe && cfg.lockKey != 8'hA5 |-> writeReq.addr == 5'h1F;
  endproperty
  a_lck: assert property (p_lck) else $error("locked write");
  property p_rst; s_phase |-> s_restart; endproperty
  a_rst: assert property (p_rst) else $error("no restart");
  property p_crc; crcCorrupt && $past(crcCorrupt) |->
    !sampleReadyOut && sampleReadyOutEn; endproperty
  a_crc: assert property (p_crc) else $error("ready free");
  property p_hiz; sampleReadyOut && !crcCorrupt && $stable(cfg.readyTristate)
    |-> sampleReadyOutEn == cfg.readyTristate; endproperty
  a_hiz: assert property (p_hiz) else $error("idle drive");
  property p_pls; |(convDone & convActive) && !crcCorrupt
    |-> ##[0:4] !sampleReadyOut; endproperty
  a_pls: assert property (p_pls) else $error("no pulse");
endmodule
bind scl_serial_loop scl_serial_loop_monitor u_mon (.clk_sys(clk_sys),
  .rst_b(rst_b), .csB(csB), .cfg(cfg), .convActive(convActive),
  .convDone(convDone), .crcCorrupt(crcCorrupt), .serialOutEn(serialOutEn),
  .writeReq(writeReq), .convRestart(convRestart),
  .sampleReadyOut(sampleReadyOut), .sampleReadyOutEn(sampleReadyOutEn));
`default_nettype wire

// ==== scl_host_model.sv ====
// host serial master model emitting edge strobes
`timescale 1ns/1ps
`default_nettype none
module scl_host_model (
  input wire logic clk_sys,
  input wire logic serialOut,
  input wire logic sckIdleHigh,
  output logic csB = 1'b1,
  output logic sckRise = 1'b0,
  output logic sckFall = 1'b0,
  output logic serialIn = 1'b0
);
  // one command byte, then bits msb first; clock still outside
  task automatic xfer(input logic [7:0] c, input logic [47:0] d,
    input int nb, output logic [47:0] rx);
    logic [55:0] sh;
    sh = {c, d};
    rx = '0;
    @(posedge clk_sys);
    csB <= 1'b0;
    for (int i = 0; i < 8 + nb; i++) begin
      @(posedge clk_sys);
      serialIn <= sh[55];
      sh = sh << 1;
      if (sckIdleHigh) begin
        // idle-high clock: fall first, data taken on the rise
        sckFall <= 1'b1;
        @(posedge clk_sys);
        sckFall <= 1'b0;
        sckRise <= 1'b1;
        @(posedge clk_sys);
        rx = {rx[46:0], serialOut};
        sckRise <= 1'b0;
      end else begin
        sckRise <= 1'b1;
        @(posedge clk_sys);
        rx = {rx[46:0], serialOut};
        sckRise <= 1'b0;
        sckFall <= 1'b1;
        @(posedge clk_sys);
        sckFall <= 1'b0;
      end
    end
    repeat (2) @(posedge clk_sys);
    csB <= 1'b1;
    // released line must not look like held data
    serialIn <= ~serialIn;
    repeat (2) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ==== scl_serial_loop_test.sv ====
// testbench for the serial loop block
`timescale 1ns/1ps
`default_nettype none
`include "scl_map.svh"
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin errorCnt++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module scl_serial_loop_test;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic csB, sckRise, sckFall, serialIn, serialOut, serialOutEn, rdyOut, rdyEn;
  logic [23:0] readWord = 24'hC3A51E;
  scl_pkg::scl_cfg_t cfg = '{2'h2, 1'b1, 1'b1, 8'hA5};
  logic [2:0] convDone = 3'h0;
  logic [2:0] conv, clr;
  logic [2:0] lastConv = 3'h0;
  logic [2:0] active = 3'h5;
  logic hi = 1'b0;
  logic [4:0] ptr;
  scl_pkg::scl_adc_cfg_t adc = '0;
  int restartCnt = 0;
  logic modHalf = 1'b0;
  logic crc = 1'b0;
  logic [5:0] tick = 6'h00;
  logic [47:0] rx;
  scl_pkg::scl_wr_t wr;
  scl_pkg::scl_wr_t wq[$];
  int errorCnt = 0;
  int checkCount = 0;
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    tick <= tick + 6'h01;
    modHalf <= tick[1];
    convDone <= (tick == 6'h3F) ? 3'h7 : 3'h0;
    if (|conv) begin
      restartCnt <= restartCnt + 1;
      lastConv <= clr;
    end
    if (wr.strobe === 1'b1) begin
      wq.push_back(wr);
    end
  end
  scl_host_model u_host (.clk_sys(clk_sys), .serialOut(serialOut),
    .sckIdleHigh(hi), .csB(csB),
    .sckRise(sckRise), .sckFall(sckFall), .serialIn(serialIn));
  scl_serial_loop u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .csB(csB),
    .sckRise(sckRise), .sckFall(sckFall), .sckIdleHigh(hi),
    .serialIn(serialIn), .readWord(readWord), .cfg(cfg),
    .adcCfg(adc), .convActive(active), .convDone(convDone),
    .modulatorClockHalf(modHalf), .crcCorrupt(crc), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .regPointer(ptr), .writeReq(wr),
    .convRestart(conv), .clearConvData(clr), .sampleReadyOut(rdyOut),
    .sampleReadyOutEn(rdyEn));
  task automatic put(input logic [4:0] a, input logic [47:0] d, input int n);
    wq.delete();
    u_host.xfer({`SCL_DEV_ADDR_DEF, a, 1'b0}, d, n, rx);
  endtask
  task automatic rd(input logic [4:0] a, input int n);
    u_host.xfer({`SCL_DEV_ADDR_DEF, a, 1'b1}, '1, n, rx);
  endtask
  task automatic count_low(output int low, output int bad, input logic en);
    low = 0;
    bad = 0;
    repeat (64) begin
      @(posedge clk_sys);
      if (rdyOut === 1'b0 && rdyEn === 1'b1)
        low++;
      else if (rdyOut !== 1'b1 || rdyEn !== en)
        bad++;
    end
  endtask
  task automatic t_loop();
    put(5'h08, 48'h123456_654321, 48);
    `CHK(wq.size(), 2)
    `CHK({wq[1].addr, wq[1].data}, {5'h09, 24'h654321})
    @(posedge clk_sys);
    cfg.writeLoop <= 1'b0;
    put(5'h1F, 48'h0000A5_0000A5, 48);
    `CHK({wq[1].addr, wq[1].data}, {5'h1F, 24'h0000A5})
    cfg.writeLoop <= 1'b1;
  endtask
  task automatic t_guard();
    put(5'h03, 48'h111111_222222, 48);
    `CHK(wq.size(), 0)
    cfg.lockKey <= 8'h00;
    put(5'h08, 48'h1, 24);
    `CHK(wq.size(), 0)
    put(5'h1F, 48'h0000A5_000000, 24);
    `CHK(wq.size(), 1)
    cfg.lockKey <= 8'hA5;
    wq.delete();
    // second byte would decode as a valid write if the frame were reopened
    u_host.xfer({2'h2, 5'h08, 1'b0}, 48'h501234_56789A, 48, rx);
    `CHK(wq.size(), 0)
  endtask
  task automatic t_phase();
    int n;
    n = restartCnt;
    put(5'h0A, 48'h000001_000000, 24);
    `CHK(restartCnt - n, 1)
    `CHK(lastConv, 3'h5)
    n = restartCnt;
    active <= 3'h2;
    adc.prescalerSel <= 2'h1;
    repeat (3) @(posedge clk_sys);
    `CHK(restartCnt - n, 1)
    `CHK(lastConv, 3'h2)
  endtask
  task automatic t_read();
    rd(5'h00, 48);
    `CHK(rx, {2{readWord}})
    `CHK(ptr, 5'h02)
  endtask
  task automatic t_mode();
    cfg.readLoop <= `SCL_RD_STATIC;
    rd(5'h01, 48);
    `CHK(rx, {2{readWord}})
    `CHK(ptr, 5'h01)
    cfg.readLoop <= `SCL_RD_FULL;
    rd(5'h1F, 24);
    `CHK(ptr, 5'h00)
    cfg.readLoop <= `SCL_RD_GROUPS;
    rd(5'h02, 24);
    `CHK(ptr, 5'h00)
    hi <= 1'b1;
    cfg.readLoop <= `SCL_RD_TYPES;
    rd(5'h00, 24);
    `CHK(rx[23:0], readWord)
    `CHK(serialOut, readWord[0])
    hi <= 1'b0;
  endtask
  task automatic t_ready();
    int low;
    int bad;
    crc <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CHK(rdyOut, 1'b0)
    `CHK(rdyEn, 1'b1)
    crc <= 1'b0;
    cfg.readyTristate <= 1'b0;
    count_low(low, bad, 1'b0);
    `CHK(low, 1)
    `CHK(bad, 0)
    cfg.readyTristate <= 1'b1; // lone ready line driven high
    count_low(low, bad, 1'b1);
    `CHK(low, 1)
    `CHK(bad, 0)
  endtask
  task automatic conclude();
    if (errorCnt == 0 && checkCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_loop();
    t_guard();
    t_phase();
    t_read();
    t_mode();
    t_ready();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    errorCnt++;
    conclude();
  end
endmodule
`default_nettype wire
